// File: common/sjcc_map.vh
`ifndef SJCC_MAP_VH
`define SJCC_MAP_VH
// register offsets (word index on the plain port)
`define SJCC_ADR_FREQ       8'h00
`define SJCC_ADR_GAIN       8'h01
`define SJCC_ADR_RUNCUR     8'h02
`define SJCC_ADR_IDLECUR    8'h03
`define SJCC_ADR_DELAY      8'h04
`define SJCC_ADR_JSPEED     8'h05
`define SJCC_ADR_JACCEL     8'h06
`define SJCC_ADR_JDECEL     8'h07
`define SJCC_ADR_HDECEL     8'h08
`define SJCC_ADR_DIR        8'h09
`define SJCC_ADR_CMD        8'h0A
`define SJCC_ADR_LIVESPD    8'h0B
`define SJCC_ADR_STATUS     8'h0C
`define SJCC_ADR_DEBOUNCE   8'h0D
`define SJCC_ADR_CONFIG     8'h0E
`define SJCC_ADR_DATAREG    8'h31
// command bits
`define SJCC_CMD_JOG        0
`define SJCC_CMD_STOPJOG    1
`define SJCC_CMD_HALT       2
`define SJCC_CMD_STOPMOVE   3
// ranges and resets
`define SJCC_FREQ_MIN       16'h0001
`define SJCC_FREQ_MAX       16'h07D0
`define SJCC_GAIN_MAX       16'h7FFF
`define SJCC_DELAY_MAX      16'h03E8
`define SJCC_FREQ_RST       16'h0001
`define SJCC_GAIN_RST       16'h0000
`define SJCC_RUNCUR_RST     16'h0000
`define SJCC_DELAY_RST      16'h0000
`define SJCC_DEBOUNCE_RST   16'h0008
// timing: idle delay in units of 10 ms, at 25 MHz
`define SJCC_DELAY_UNIT_NS  10000000
`define SJCC_CLK_NS         40
`define SJCC_TICK_CYCLES    (`SJCC_DELAY_UNIT_NS / `SJCC_CLK_NS)
// one debounce tick is 2 ms / 8 = 250 us
`define SJCC_DEB_TICK_NS    250000
`define SJCC_DEB_CYCLES     (`SJCC_DEB_TICK_NS / `SJCC_CLK_NS)
`endif

// File: verilog/sjcc_core.v
// Operation
// - frequency register 1..2000 hz, read and write, fed to filter output
// - gain register 0..32767, read and write, fed to filter output
// - phase current uses idle level once the motor has stopped and the idle delay has run out
// - idle delay counted from last step before dropping to idle current
// - first variant: idle writes above running current clamp to running current
// - first variant: running write below idle sets idle to running value
// - second variant: idle writes limited to 90 percent of running current
// - second variant: each running write sets idle to half the value
// - idle current also readable at data register 031 in other units
// - jog start ramps at jog accel up to jog speed, then runs on
// - stop jog ramps down at jog decel
// - quick halt ramps down at the faster halt decel
// - jog direction is the direction setting at jog start, changed by bit 15 of a live speed write
// - live speed change during jog leaves stored jog speed alone
// - jog start always takes stored speed and direction, command not stored
// - stored programs stop a jog with stop move, not immediate stops
// - live speed register in 0.25 rpm units alters speed while jogging
// - debounce setting 8 ticks gives a 2 ms filter on the input
// - stop move with decel option uses jog decel ramp
// - idle delay 0..10 s, restarted by each received step pulse
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "sjcc_map.vh"
module sjcc_core #(
  parameter integer TICK_CYCLES = `SJCC_TICK_CYCLES,
  parameter integer DEB_CYCLES  = `SJCC_DEB_CYCLES
) (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire [7:0]  addr_in,
  input  wire [15:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [15:0] rdata_out,
  input  wire        step_pulse_in,
  input  wire        sense_in,
  output reg         sense_filt_out,
  output reg  [15:0] phase_cur_out,
  output reg  [15:0] speed_out,
  output reg         dir_out,
  output reg         moving_out,
  output reg  [15:0] anti_res_freq_out,
  output reg  [15:0] anti_res_gain_out
);

  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  reg [15:0] freq_ff, gain_ff, run_ff, idle_ff, delay_ff;
  reg [15:0] jspeed_ff, jaccel_ff, jdecel_ff, hdecel_ff, deb_ff;
  reg        dir_ff, variant_ff;
  reg [15:0] target_ff, rate_ff;
  reg [2:0]  st_ff;
  reg        step_s1_ff, step_s2_ff, step_s3_ff;
  reg        sns_s1_ff, sns_s2_ff;
  reg [15:0] deb_cnt_ff;
  reg [31:0] deb_div_ff;
  reg [31:0] tick_ff;
  reg [15:0] idle_cnt_ff;

  // one-hot jog states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN  = 3'b010;
  localparam [2:0] ST_STOP = 3'b100;

  wire        wr_cmd       = wr_in && (addr_in == `SJCC_ADR_CMD);
  // 90 percent limit, floored; the product is kept at 32 bits so it cannot wrap
  wire [31:0] lim90_full   = ({16'h0000, run_ff} * 32'd9) / 32'd10;
  wire [15:0] lim90        = lim90_full[15:0];
  wire        step_edge    = step_s2_ff & ~step_s3_ff;

  // idle current write value after variant limits
  function [15:0] clamp_idle;
    input [15:0] v;
    input        var2;
    input [15:0] run;
    input [15:0] l90;
    begin
      if (var2) clamp_idle = (v > l90) ? l90 : v;
      else      clamp_idle = (v > run) ? run : v;
    end
  endfunction

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      freq_ff <= `SJCC_FREQ_RST;
      gain_ff <= `SJCC_GAIN_RST;
      run_ff <= `SJCC_RUNCUR_RST;
      idle_ff <= 16'h0000;
      delay_ff <= `SJCC_DELAY_RST;
      jspeed_ff <= 16'h0000;
      jaccel_ff <= 16'h0001;
      jdecel_ff <= 16'h0001;
      hdecel_ff <= 16'h0001;
      deb_ff <= `SJCC_DEBOUNCE_RST;
      dir_ff <= 1'b0;
      variant_ff <= 1'b0;
    end else if (wr_in) begin
      case (addr_in)
        `SJCC_ADR_FREQ: begin
          if (wdata_in < `SJCC_FREQ_MIN) freq_ff <= `SJCC_FREQ_MIN;
          else if (wdata_in > `SJCC_FREQ_MAX) freq_ff <= `SJCC_FREQ_MAX;
          else freq_ff <= wdata_in;
        end
        `SJCC_ADR_GAIN:     gain_ff <= (wdata_in > `SJCC_GAIN_MAX) ? `SJCC_GAIN_MAX : wdata_in;
        `SJCC_ADR_RUNCUR: begin
          run_ff <= wdata_in;
          if (variant_ff) idle_ff <= {1'b0, wdata_in[15:1]};
          else if (wdata_in < idle_ff) idle_ff <= wdata_in;
        end
        `SJCC_ADR_IDLECUR:  idle_ff <= clamp_idle(wdata_in, variant_ff, run_ff, lim90);
        `SJCC_ADR_DATAREG:  idle_ff <= clamp_idle({wdata_in[7:0], 8'h00} >> 4, variant_ff, run_ff, lim90);
        `SJCC_ADR_DELAY:    delay_ff <= (wdata_in > `SJCC_DELAY_MAX) ? `SJCC_DELAY_MAX : wdata_in;
        `SJCC_ADR_JSPEED:   jspeed_ff <= wdata_in;
        `SJCC_ADR_JACCEL:   jaccel_ff <= (wdata_in == 16'h0000) ? 16'h0001 : wdata_in;
        `SJCC_ADR_JDECEL:   jdecel_ff <= (wdata_in == 16'h0000) ? 16'h0001 : wdata_in;
        `SJCC_ADR_HDECEL:   hdecel_ff <= (wdata_in == 16'h0000) ? 16'h0001 : wdata_in;
        `SJCC_ADR_DIR:      dir_ff <= wdata_in[0];
        `SJCC_ADR_DEBOUNCE: deb_ff <= wdata_in;
        `SJCC_ADR_CONFIG:   variant_ff <= wdata_in[0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // jog state machine and speed ramp
  // ----------------------------------------------------------------
  // the ramp moves speed_out by rate_ff each cycle toward target_ff
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_ff <= ST_IDLE;
      target_ff <= 16'h0000;
      rate_ff <= 16'h0001;
      speed_out <= 16'h0000;
      dir_out <= 1'b0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (wr_cmd && wdata_in[`SJCC_CMD_JOG]) begin
            st_ff <= ST_RUN;
            target_ff <= jspeed_ff;
            dir_out <= dir_ff;
            rate_ff <= jaccel_ff;
          end
        end
        ST_RUN: begin
          if (wr_cmd && wdata_in[`SJCC_CMD_HALT]) begin
            st_ff <= ST_STOP;
            target_ff <= 16'h0000;
            rate_ff <= hdecel_ff;
          end else if (wr_cmd && (wdata_in[`SJCC_CMD_STOPJOG] || wdata_in[`SJCC_CMD_STOPMOVE])) begin
            st_ff <= ST_STOP;
            target_ff <= 16'h0000;
            rate_ff <= jdecel_ff;
          end else if (wr_in && (addr_in == `SJCC_ADR_LIVESPD)) begin
            target_ff <= {1'b0, wdata_in[14:0]};
            dir_out <= wdata_in[15];
            rate_ff <= jaccel_ff;
          end
        end
        ST_STOP: begin
          if (wr_cmd && wdata_in[`SJCC_CMD_HALT]) rate_ff <= hdecel_ff;
          if (speed_out == 16'h0000) st_ff <= ST_IDLE;
        end
        default: st_ff <= ST_IDLE;
      endcase
      // ramp step, saturating at the target
      if (speed_out < target_ff)
        speed_out <= (target_ff - speed_out > rate_ff) ? speed_out + rate_ff : target_ff;
      else if (speed_out > target_ff)
        speed_out <= (speed_out - target_ff > rate_ff) ? speed_out - rate_ff : target_ff;
    end
  end

  // ----------------------------------------------------------------
  // idle current delay
  // ----------------------------------------------------------------
  // step pulse is a pin: two flops before any logic, third for the edge
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      step_s1_ff <= 1'b0;
      step_s2_ff <= 1'b0;
      step_s3_ff <= 1'b0;
      tick_ff <= 32'h0000_0000;
      idle_cnt_ff <= 16'h0000;
      moving_out <= 1'b0;
      phase_cur_out <= 16'h0000;
    end else begin
      step_s1_ff <= step_pulse_in;
      step_s2_ff <= step_s1_ff;
      step_s3_ff <= step_s2_ff;
      moving_out <= (speed_out != 16'h0000) || step_edge;
      if ((speed_out != 16'h0000) || step_edge) begin
        idle_cnt_ff <= delay_ff;
        tick_ff <= 32'h0000_0000;
      end else if (idle_cnt_ff != 16'h0000) begin
        if (tick_ff >= TICK_CYCLES - 1) begin
          tick_ff <= 32'h0000_0000;
          idle_cnt_ff <= idle_cnt_ff - 16'h0001;
        end else begin
          tick_ff <= tick_ff + 32'h0000_0001;
        end
      end
      if ((speed_out != 16'h0000) || step_edge || (idle_cnt_ff != 16'h0000))
        phase_cur_out <= run_ff;
      else
        phase_cur_out <= idle_ff;
    end
  end

  // ----------------------------------------------------------------
  // input debounce
  // ----------------------------------------------------------------
  // input must hold steady for deb_ff ticks of 250 us
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      sns_s1_ff <= 1'b0;
      sns_s2_ff <= 1'b0;
      deb_cnt_ff <= 16'h0000;
      deb_div_ff <= 32'h0000_0000;
      sense_filt_out <= 1'b0;
    end else begin
      sns_s1_ff <= sense_in;
      sns_s2_ff <= sns_s1_ff;
      if (sns_s2_ff == sense_filt_out) begin
        deb_cnt_ff <= 16'h0000;
        deb_div_ff <= 32'h0000_0000;
      end else if (deb_div_ff >= DEB_CYCLES - 1) begin
        deb_div_ff <= 32'h0000_0000;
        if (deb_cnt_ff + 16'h0001 >= deb_ff) begin
          sense_filt_out <= sns_s2_ff;
          deb_cnt_ff <= 16'h0000;
        end else begin
          deb_cnt_ff <= deb_cnt_ff + 16'h0001;
        end
      end else begin
        deb_div_ff <= deb_div_ff + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // filter outputs and read port
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      anti_res_freq_out <= `SJCC_FREQ_RST;
      anti_res_gain_out <= `SJCC_GAIN_RST;
      rdata_out <= 16'h0000;
    end else begin
      anti_res_freq_out <= freq_ff;
      anti_res_gain_out <= gain_ff;
      rdata_out <= 16'h0000;
      if (rd_in) begin
        case (addr_in)
          `SJCC_ADR_FREQ:     rdata_out <= freq_ff;
          `SJCC_ADR_GAIN:     rdata_out <= gain_ff;
          `SJCC_ADR_RUNCUR:   rdata_out <= run_ff;
          `SJCC_ADR_IDLECUR:  rdata_out <= idle_ff;
          `SJCC_ADR_DATAREG:  rdata_out <= {8'h00, idle_ff[11:4]};
          `SJCC_ADR_DELAY:    rdata_out <= delay_ff;
          `SJCC_ADR_JSPEED:   rdata_out <= jspeed_ff;
          `SJCC_ADR_JACCEL:   rdata_out <= jaccel_ff;
          `SJCC_ADR_JDECEL:   rdata_out <= jdecel_ff;
          `SJCC_ADR_HDECEL:   rdata_out <= hdecel_ff;
          `SJCC_ADR_DIR:      rdata_out <= {15'h0000, dir_ff};
          `SJCC_ADR_LIVESPD:  rdata_out <= {dir_out, speed_out[14:0]};
          `SJCC_ADR_STATUS:   rdata_out <= {11'h000, sense_filt_out, moving_out, st_ff};
          `SJCC_ADR_DEBOUNCE: rdata_out <= deb_ff;
          `SJCC_ADR_CONFIG:   rdata_out <= {15'h0000, variant_ff};
          default:            rdata_out <= 16'h0000;
        endcase
      end
    end
  end

endmodule // sjcc_core

// File: tb/sjcc_core_sva.sv
`timescale 1ns/1ps
// ---------------
// port checker
// ---------------
module sjcc_core_chk (
  input wire        clk_in,
  input wire        rst_n_in,
  input wire [7:0]  addr_in,
  input wire [15:0] wdata_in,
  input wire        wr_in,
  input wire        rd_in,
  input wire [15:0] rdata_out,
  input wire [15:0] speed_out,
  input wire        moving_out,
  input wire [15:0] anti_res_freq_out,
  input wire [15:0] anti_res_gain_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // clamp applied to a written frequency
  function automatic [15:0] f_clamp(input [15:0] w);
    f_clamp = (w < 16'h0001) ? 16'h0001 : ((w > 16'h07D0) ? 16'h07D0 : w);
  endfunction
  rd_idle_zero_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data not zero outside read slot");
  freq_range_a: assert property (anti_res_freq_out >= 16'h0001 && anti_res_freq_out <= 16'h07D0)
    else $error("filter frequency out of range");
  gain_range_a: assert property (anti_res_gain_out <= 16'h7FFF)
    else $error("filter gain out of range");
  freq_follow_a: assert property (wr_in && addr_in == 8'h00 |=> ##1 anti_res_freq_out == f_clamp($past(wdata_in, 2)))
    else $error("filter frequency output did not follow write");
  gain_follow_a: assert property (wr_in && addr_in == 8'h01 && !wdata_in[15] |=> ##1 anti_res_gain_out == $past(wdata_in, 2))
    else $error("filter gain output did not follow write");
  unmapped_read_a: assert property (rd_in && addr_in > 8'h0E && addr_in != 8'h31 |=> rdata_out == 16'h0000)
    else $error("unmapped read returned data");
  data_reg_a: assert property (rd_in && addr_in == 8'h31 |=> rdata_out[15:8] == 8'h00)
    else $error("data register wider than its field");
  moving_speed_a: assert property ((speed_out != 16'h0000) [*2] |-> moving_out)
    else $error("motor turning without moving flag");
  cover property (wr_in && addr_in == 8'h0A && wdata_in[0]);
  cover property ($fell(speed_out != 16'h0000));
  cover property (rd_in && addr_in == 8'h31);
endmodule // sjcc_core_chk
bind sjcc_core sjcc_core_chk u_chk (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
  .speed_out, .moving_out, .anti_res_freq_out, .anti_res_gain_out);

// File: tb/sjcc_host.sv
`timescale 1ns/1ps
// ---------------
// host model
// ---------------
module sjcc_host (
  input  wire        clk_in,
  input  wire [15:0] rdata_in,
  output reg  [7:0]  addr_out,
  output reg  [15:0] wdata_out,
  output reg         wr_out,
  output reg         rd_out
);
  initial begin
    addr_out = 8'h00;
    wdata_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // one-cycle write; wr_out is raised for a single clock
  task wr_reg(input [7:0] a, input [15:0] d);
    begin
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
    end
  endtask
  // read data stands only in the cycle after the strobe
  task rd_reg(input [7:0] a, output [15:0] d);
    begin
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      #1 d = rdata_in;
    end
  endtask
  // a stored program ends a jog with stop move, never an immediate stop
  task prog_stop;
    wr_reg(8'h0A, 16'h0008);
  endtask
endmodule // sjcc_host

// File: tb/sjcc_core_test.sv
`timescale 1ns/1ps
`include "sjcc_map.vh"
module sjcc_core_test;
  reg         clk_in = 1'b0;
  reg         rst_n_in = 1'b0;
  reg         step_pulse_in = 1'b0;
  reg         sense_in = 1'b0;
  wire [7:0]  addr;
  wire [15:0] wdata, rdata, phase_cur, speed, freq, gain;
  wire        wr, rd, sense_filt, dir, moving;
  integer     error_cnt = 0;
  integer     samples_checked = 0;
  reg  [15:0] v;
  always #20 clk_in = ~clk_in;
  // short tick counts keep the idle delay and debounce runs brief
  sjcc_core #(.TICK_CYCLES(4), .DEB_CYCLES(2)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .step_pulse_in(step_pulse_in),
    .sense_in(sense_in), .sense_filt_out(sense_filt), .phase_cur_out(phase_cur), .speed_out(speed),
    .dir_out(dir), .moving_out(moving), .anti_res_freq_out(freq), .anti_res_gain_out(gain));
  sjcc_host u_host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
    .rd_out(rd));
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task rchk(input [7:0] a, input [15:0] exp);
    begin
      u_host.rd_reg(a, v);
      chk(v, exp);
    end
  endtask
  task wchk(input [7:0] a, input [15:0] d, input [15:0] exp);
    begin
      u_host.wr_reg(a, d);
      rchk(a, exp);
    end
  endtask
  // sample after the edge has settled
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk_in);
      #1;
    end
  endtask
  task end_of_test;
    begin
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // ---------------
  // test sequence
  // ---------------
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rchk(`SJCC_ADR_FREQ, 16'h0001);
    rchk(`SJCC_ADR_DEBOUNCE, 16'h0008);
    wchk(`SJCC_ADR_FREQ, 16'h0BB8, 16'h07D0);
    wchk(`SJCC_ADR_FREQ, 16'h0000, 16'h0001);
    wchk(`SJCC_ADR_FREQ, 16'h0578, 16'h0578);
    wchk(`SJCC_ADR_GAIN, 16'hFFFF, 16'h7FFF);
    wchk(`SJCC_ADR_GAIN, 16'h0320, 16'h0320);
    chk(gain, 16'h0320);
    chk(freq, 16'h0578);
    rchk(8'h20, 16'h0000);
    $display("settings test done");
    wchk(`SJCC_ADR_RUNCUR, 16'h0064, 16'h0064);
    wchk(`SJCC_ADR_IDLECUR, 16'h00C8, 16'h0064);
    wchk(`SJCC_ADR_RUNCUR, 16'h0032, 16'h0032);
    rchk(`SJCC_ADR_IDLECUR, 16'h0032);
    u_host.wr_reg(`SJCC_ADR_CONFIG, 16'h0001);
    wchk(`SJCC_ADR_RUNCUR, 16'h0100, 16'h0100);
    rchk(`SJCC_ADR_IDLECUR, 16'h0080);
    rchk(`SJCC_ADR_DATAREG, 16'h0008);
    wchk(`SJCC_ADR_IDLECUR, 16'h00FF, 16'h00E6);
    wchk(`SJCC_ADR_IDLECUR, 16'h0040, 16'h0040);
    @(posedge clk_in);
    sense_in <= 1'b1;
    cyc(40);
    chk(sense_filt, 1'b1);
    $display("current test done");
    u_host.wr_reg(`SJCC_ADR_DIR, 16'h0001);
    u_host.wr_reg(`SJCC_ADR_JSPEED, 16'h000A);
    u_host.wr_reg(`SJCC_ADR_JACCEL, 16'h0002);
    u_host.wr_reg(`SJCC_ADR_JDECEL, 16'h0001);
    u_host.wr_reg(`SJCC_ADR_HDECEL, 16'h0005);
    u_host.wr_reg(`SJCC_ADR_DELAY, 16'h0002);
    u_host.wr_reg(`SJCC_ADR_CMD, 16'h0001);
    cyc(2);
    chk(speed < 16'h000A, 1'b1);
    cyc(20);
    chk(speed, 16'h000A);
    chk(dir, 1'b1);
    chk(phase_cur, 16'h0100);
    chk(moving, 1'b1);
    u_host.wr_reg(`SJCC_ADR_LIVESPD, 16'h8014);
    cyc(20);
    chk(speed, 16'h0014);
    rchk(`SJCC_ADR_JSPEED, 16'h000A);
    u_host.wr_reg(`SJCC_ADR_CMD, 16'h0002);
    cyc(5);
    chk(speed != 16'h0000, 1'b1);
    cyc(30);
    chk(speed, 16'h0000);
    cyc(30);
    chk(phase_cur, 16'h0040);
    u_host.wr_reg(`SJCC_ADR_CMD, 16'h0001);
    cyc(20);
    chk(speed, 16'h000A);
    u_host.wr_reg(`SJCC_ADR_CMD, 16'h0004);
    cyc(4);
    chk(speed, 16'h0000);
    chk(phase_cur, 16'h0100);
    cyc(30);
    chk(phase_cur, 16'h0040);
    u_host.wr_reg(`SJCC_ADR_CMD, 16'h0001);
    cyc(20);
    u_host.prog_stop;
    cyc(5);
    chk(speed != 16'h0000, 1'b1);
    cyc(30);
    chk(speed, 16'h0000);
    $display("jog test done");
    @(posedge clk_in);
    step_pulse_in <= 1'b1;
    @(posedge clk_in);
    step_pulse_in <= 1'b0;
    cyc(3);
    chk(phase_cur, 16'h0100);
    cyc(40);
    chk(phase_cur, 16'h0040);
    $display("step test done");
    end_of_test;
  end
  // watchdog well beyond the roughly 400 cycles the tests need
  initial begin
    #(40 * 4000);
    error_cnt = error_cnt + 1;
    end_of_test;
  end
endmodule // sjcc_core_test
